// file: inc/spd_cfg.svh
/*
 * Constants of the page decoder and exception summary block.
 * Assumes inclusion by its bare name; definitions only.
 */
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH
// Frame layout, command side
`define SPD_FRAME_BITS 32
`define SPD_RW_POS 31
`define SPD_ADDR_HI 30
`define SPD_ADDR_LO 23
`define SPD_DATA_HI 20
`define SPD_DATA_LO 5
// Frame layout, response side
`define SPD_SUM_HI_POS 30
`define SPD_SUM_LO_POS 29
`define SPD_FDBK_HI 28
`define SPD_FDBK_LO 21
// Page bases
`define SPD_CH0_BASE 8'h00
`define SPD_CH1_BASE 8'h20
`define SPD_CH2_BASE 8'h40
`define SPD_CH3_BASE 8'h60
`define SPD_FREE4_BASE 8'h80
`define SPD_FREE5_BASE 8'hA0
`define SPD_GENERAL_PAGE_BASE 8'hC0
`define SPD_FAULT_TEST_PAGE_BASE 8'hE0
// Mask applied to exception word a
`define SPD_WORD_A_MASK 16'hF87F
// Response held until the first frame completes
`define SPD_RESET_RSP 32'h0000_0000
`endif

// file: inc/spd_pkg.sv
/*
 * Types of the page decoder and exception summary block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package spd_pkg;
  // Page identifier, upper three address bits
  typedef enum logic [2:0] {
    SPD_PG_CH0 = 3'h0,
    SPD_PG_CH1 = 3'h1,
    SPD_PG_CH2 = 3'h2,
    SPD_PG_CH3 = 3'h3,
    SPD_PG_FREE4 = 3'h4,
    SPD_PG_FREE5 = 3'h5,
    SPD_PG_GENERAL = 3'h6,
    SPD_PG_FAULT = 3'h7
  } spd_page_t;
  // One register access toward the banks
  typedef struct packed {
    logic wr;
    logic rd;
    spd_page_t page;
    logic [4:0] idx;
    logic [15:0] data;
  } spd_access_t;
  // Bank selects decoded from the page
  typedef struct packed {
    logic [3:0] ch;
    logic general;
    logic fault;
  } spd_sel_t;
endpackage

// file: rtl/spd_page_decode.sv
/*
 * SPI slave front end: frame capture on the link clock, page decode,
 * exception summary and out-of-frame response on the core clock.
 * Assumes the master keeps chip select high long enough between frames
 * for the core clock to settle the response (many core cycles).
 */
// Function
// RQ1 - Bit 29 ORs channel 0/1 exceptions
// RQ2 - Bit 30 ORs channel 2/3 exceptions
// RQ3 - Summary bits present in every response; first response after reset is all zeros
// RQ4 - Command carries 8-bit address, 16-bit data
// RQ5 - Address splits into page and index
// RQ6 - Pages 0-3 select channel banks
// RQ7 - Pages 4-5 unused, 6 general, 7 fault
// RQ8 - Response returns previous command's outcome
// RQ9 - Unused pages read zero, ignore writes
`timescale 1ns/1ps
`include "spd_cfg.svh"
module spd_page_decode (
  // Core clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Exception words per channel
  input wire logic [3:0][15:0] channel_exception_word_a,
  input wire logic [3:0][15:0] channel_exception_word_b,
  // Register bank access
  output spd_pkg::spd_access_t acc,
  output spd_pkg::spd_sel_t sel,
  input wire logic [15:0] rd_data
);
  // Link domain state
  logic [4:0] bit_cnt; // Rising edges in this frame
  logic [30:0] rx_sh; // Bits received so far
  logic [31:0] frame_word; // Last complete command
  logic frame_tog; // Flips once per frame
  logic tx_bit; // Bit shifted out
  logic tx_started; // First falling edge seen
  wire logic link_clr = cs_n | srst; // Ends frame state

  // Core domain state
  logic tog_s1, tog_s2, tog_s3; // Toggle synchroniser
  logic acc_valid; // Access cycle
  logic rsp_load; // Response capture cycle
  logic [31:0] rsp_word; // Response of last command
  logic unused_pg; // Access hit an unused page

  // Receive: count and shift on rising edge
  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt <= 5'h00;
      rx_sh <= 31'h0000_0000;
    end else begin
      bit_cnt <= bit_cnt + 5'h01;
      rx_sh <= {rx_sh[29:0], mosi};
    end
  end

  // Complete frame handed over with a toggle
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      frame_word <= 32'h0000_0000;
      frame_tog <= 1'b0;
    end else if (bit_cnt == 5'h1F) begin
      frame_word <= {rx_sh, mosi};
      frame_tog <= ~frame_tog;
    end
  end

  // Transmit: next bit on falling edge
  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      tx_bit <= 1'b0;
      tx_started <= 1'b0;
    end else begin
      tx_bit <= rsp_word[~bit_cnt];
      tx_started <= 1'b1;
    end
  end

  // Bit 31 shows before the first falling edge; response is quiet then
  assign miso = tx_started ? tx_bit : rsp_word[31];
  assign miso_oe = ~cs_n;

  // Toggle synchroniser into the core clock
  always_ff @(posedge clk) begin
    if (srst) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= frame_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end
  wire logic frame_evt = tog_s2 ^ tog_s3; // New frame, word now stable

  // Address split into page and index
  wire logic [7:0] cmd_addr = frame_word[`SPD_ADDR_HI:`SPD_ADDR_LO]; // RQ4
  wire spd_pkg::spd_page_t cmd_page = spd_pkg::spd_page_t'(cmd_addr[7:5]); // RQ5
  wire logic [4:0] cmd_idx = cmd_addr[4:0]; // RQ5
  wire logic cmd_wr = frame_word[`SPD_RW_POS];
  wire logic cmd_free = (cmd_page == spd_pkg::SPD_PG_FREE4) ||
                        (cmd_page == spd_pkg::SPD_PG_FREE5);

  // Issue one access per frame; unused pages get no strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      acc <= '0;
      acc_valid <= 1'b0;
      unused_pg <= 1'b0;
    end else begin
      acc_valid <= frame_evt;
      if (frame_evt) begin
        acc.wr <= cmd_wr & ~cmd_free; // RQ9
        acc.rd <= ~cmd_wr & ~cmd_free; // RQ9
        acc.page <= cmd_page;
        acc.idx <= cmd_idx;
        acc.data <= frame_word[`SPD_DATA_HI:`SPD_DATA_LO]; // RQ4
        unused_pg <= cmd_free;
      end else begin
        acc.wr <= 1'b0;
        acc.rd <= 1'b0;
      end
    end
  end

  // Bank selects held from the last command's page
  assign sel.ch[0] = acc.page == spd_pkg::SPD_PG_CH0; // RQ6
  assign sel.ch[1] = acc.page == spd_pkg::SPD_PG_CH1; // RQ6
  assign sel.ch[2] = acc.page == spd_pkg::SPD_PG_CH2; // RQ6
  assign sel.ch[3] = acc.page == spd_pkg::SPD_PG_CH3; // RQ6
  assign sel.general = acc.page == spd_pkg::SPD_PG_GENERAL; // RQ7
  assign sel.fault = acc.page == spd_pkg::SPD_PG_FAULT; // RQ7

  // Exception summaries of each channel pair
  wire logic [3:0] ch_exc; // Per channel any exception outside the word a mask
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_exc
      assign ch_exc[g] = |(channel_exception_word_a[g] & `SPD_WORD_A_MASK) |
                         |channel_exception_word_b[g];
    end
  endgenerate
  wire logic sum_lo = ch_exc[0] | ch_exc[1]; // RQ1
  wire logic sum_hi = ch_exc[2] | ch_exc[3]; // RQ2

  // Build the response after the access settled
  assign rsp_load = acc_valid;
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_word <= `SPD_RESET_RSP;
    end else if (rsp_load) begin
      rsp_word[31] <= 1'b0;
      rsp_word[`SPD_SUM_HI_POS] <= sum_hi; // RQ2 RQ3 RQ8
      rsp_word[`SPD_SUM_LO_POS] <= sum_lo; // RQ1 RQ3 RQ8
      rsp_word[`SPD_FDBK_HI:`SPD_FDBK_LO] <= {acc.page, acc.idx}; // RQ8
      rsp_word[`SPD_DATA_HI:`SPD_DATA_LO] <= unused_pg ? 16'h0000 : rd_data; // RQ9
      rsp_word[4:0] <= 5'h00;
    end
  end

  // Checks
  // Frame seen, then access issued
  sequence s_issue;
    frame_evt ##1 acc_valid;
  endsequence
  // Response rebuilt next cycle: fixed bits and fresh summaries
  sequence s_answer;
    ##1 !rsp_word[31] && (rsp_word[4:0] == 5'h00) &&
    (rsp_word[30:29] == $past({sum_hi, sum_lo}));
  endsequence
  // Every frame gets a response with both summaries
  frame_answer_a: assert property (@(posedge clk) disable iff (srst) // RQ3
    s_issue |-> s_answer) else $error("frame not answered");
  // Low summary against channel 0/1 words at load
  sum_lo_a: assert property (@(posedge clk) disable iff (srst) // RQ1
    rsp_load |=> rsp_word[`SPD_SUM_LO_POS] == $past(
    (|((channel_exception_word_a[0] | channel_exception_word_a[1]) & `SPD_WORD_A_MASK)) ||
    (|channel_exception_word_b[1:0]))) else $error("low summary wrong");
  // High summary against channel 2/3 words at load
  sum_hi_a: assert property (@(posedge clk) disable iff (srst) // RQ2
    rsp_load |=> rsp_word[`SPD_SUM_HI_POS] == $past(
    (|((channel_exception_word_a[2] | channel_exception_word_a[3]) & `SPD_WORD_A_MASK)) ||
    (|channel_exception_word_b[3:2]))) else $error("high summary wrong");
  // Address of the frame echoed in the next response
  addr_fdbk_a: assert property (@(posedge clk) disable iff (srst) // RQ8
    frame_evt |-> ##2 rsp_word[28:21] == $past(cmd_addr, 2))
    else $error("address feedback wrong");
  // Response only moves on a load
  rsp_hold_a: assert property (@(posedge clk) disable iff (srst) // RQ8
    !rsp_load |=> $stable(rsp_word)) else $error("response moved");
  // Page and index taken from the address field
  page_split_a: assert property (@(posedge clk) disable iff (srst) // RQ5
    frame_evt |=> acc.page == $past(frame_word[30:28]) &&
    acc.idx == $past(frame_word[27:23])) else $error("bad split");
  // One channel bank per channel page
  ch_sel_a: assert property (@(posedge clk) disable iff (srst) // RQ6
    acc_valid && acc.page < 3'h4 |-> sel.ch == 4'h1 << acc.page)
    else $error("channel select wrong");
  // General, fault and unused pages
  misc_sel_a: assert property (@(posedge clk) disable iff (srst) // RQ7
    acc_valid |-> sel.general == (acc.page == 3'h6) &&
    sel.fault == (acc.page == 3'h7) && (acc.page[2:1] != 2'b10 ||
    (sel == '0))) else $error("page select wrong");
  // Unused pages: no strobe, zero data
  free_page_a: assert property (@(posedge clk) disable iff (srst) // RQ9
    acc_valid && unused_pg |-> !acc.wr && !acc.rd ##1
    rsp_word[20:5] == 16'h0000) else $error("unused page acted");
  // Write carries the frame's data word
  data_path_a: assert property (@(posedge clk) disable iff (srst) // RQ4
    frame_evt && cmd_wr && !cmd_free |=> acc.wr &&
    acc.data == $past(frame_word[20:5])) else $error("write lost");
  // Strobes last one cycle and never both
  acc_pulse_a: assert property (@(posedge clk) disable iff (srst) // RQ4
    acc.wr || acc.rd |-> !(acc.wr && acc.rd) ##1 !acc.wr && !acc.rd)
    else $error("strobe too long");
endmodule

// file: sim/spd_master.sv
/* SPI master model that stands across the link from the page decoder.
   Assumes the bench calls xfer once per frame and nothing else drives the link. */
`timescale 1ns/1ps
module spd_master (
  // Link pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // Idle link: clock still, select high, data at pull-down level
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One 32-bit frame at 8 MHz, MSB first, miso taken at each rising edge
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
    #3.3 cs_n = 1'b0;
    #130;
    for (int b = 31; b >= 0; b--) begin
      mosi = cmd[b];
      #62.5 sclk = 1'b1;
      rsp[b] = miso;
      #62.5 sclk = 1'b0;
    end
    #50 cs_n = 1'b1;
    mosi = 1'b0;
    // Select held high so the delayed answer settles
    #700;
  endtask
endmodule

// file: sim/tb.sv
/* Bench of the page decoder: page walk, unused pages, exception summaries.
   Assumes spd_master on the link and a combinational bank model here. */
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic [3:0][15:0] wa = '0; // Exception words a
  logic [3:0][15:0] wb = '0; // Exception words b
  spd_pkg::spd_access_t acc;
  spd_pkg::spd_sel_t sel;
  logic [15:0] rd_data;
  logic [31:0] rsp;
  int fail_count = 0;
  int checks = 0;
  int pulses = 0; // Bank access pulses seen
  int writes = 0; // Bank write pulses seen
  // Core clock, 5 ns period
  always #2.5 clk = ~clk;
  // Bank answers with a marker and the index
  assign rd_data = {8'hA5, 3'h0, acc.idx};
  // Counts read and write pulses toward the banks
  always @(posedge clk) if (acc.wr || acc.rd) pulses++;
  always @(posedge clk) if (acc.wr) writes++;
  spd_page_decode i_spd_page_decode (.clk(clk), .srst(srst), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .channel_exception_word_a(wa), .channel_exception_word_b(wb),
    .acc(acc), .sel(sel), .rd_data(rd_data));
  spd_master i_spd_master (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // Compares and counts
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Prints counts and verdict, ends the run
  task automatic end_sim();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Every page in turn, reads and writes, decode and delayed answer
  task automatic page_walk();
    logic [7:0] a;
    logic [7:0] pa;
    logic [15:0] pd;
    logic [5:0] s;
    for (int p = 0; p <= 8; p++) begin
      a = {p[2:0], 5'(31 - p)};
      i_spd_master.xfer({p[0], a, 2'b00, 8'h5A, a, 5'h00}, rsp);
      chk(32'(miso_oe), 32'h0);
      chk(32'(acc.data), {16'h0000, 8'h5A, a});
      // First answer after reset is all zeros
      if (p == 0) chk(rsp, 32'h0);
      else chk(rsp, {3'b000, pa, pd, 5'h00});
      s = (p[2:0] < 3'd4) ? {4'(1 << p[2:0]), 2'b00}
                          : {4'h0, p[2:0] == 3'd6, p[2:0] == 3'd7};
      chk(32'(sel), 32'(s));
      chk(32'(acc.idx), 32'(31 - p));
      pa = a;
      // Unused pages answer with zero data
      pd = (a[7:5] == 3'd4 || a[7:5] == 3'd5) ? 16'h0 : {8'hA5, 3'h0, a[4:0]};
    end
    // No bank access for pages 4 and 5
    chk(32'(pulses), 32'd7);
    chk(32'(writes), 32'd3);
  endtask
  // Unmasked flags raised before a frame show in the next frame's summaries
  task automatic exc_sum();
    logic [9:0] e;
    e = 10'b11_10_01_00_00;
    for (int k = 0; k <= 5; k++) begin
      @(negedge clk);
      wa = '0;
      wb = '0;
      case (k)
        1: wa[0] = 16'h0780;
        2: wa[1] = 16'h0001;
        3: wb[3] = 16'h8000;
        4: begin
          wa[2] = 16'h8000;
          wb[0] = 16'h0001;
        end
        default: ;
      endcase
      // Output driven while the frame runs
      fork
        i_spd_master.xfer({1'b0, 8'h06, 23'h0}, rsp);
        begin
          #300;
          chk(32'(miso_oe), 32'h1);
        end
      join
      if (k > 0) chk(32'(rsp[30:29]), 32'(e[2*(k-1) +: 2]));
    end
  endtask
  // Reset for 5 cycles, then the scenarios
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    page_walk();
    exc_sum();
    end_sim();
  end
  // Watchdog well past the 15 frames
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
endmodule
